/* pkg/fan_status_pkg.sv */
`default_nettype none

package fan_status_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0]  EVENT_STATUS_SECOND_IDX = 8'h42;
  localparam logic [7:0]  CPU_VOLTAGE_CODE_IDX    = 8'h43;
  localparam logic [11:0] EVENT_STATUS_SECOND_ADDR =
    {2'b00, EVENT_STATUS_SECOND_IDX, 2'b00};
  localparam logic [11:0] CPU_VOLTAGE_CODE_ADDR =
    {2'b00, CPU_VOLTAGE_CODE_IDX, 2'b00};
  localparam logic [11:0] MONITOR_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] FLAG_ENABLE_ADDR    = 12'h004;
  localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h008;
  localparam logic [11:0] IRQ_MASK_ADDR       = 12'h00C;
  localparam logic [11:0] DIODE_LIMIT_ADDR    = 12'h010;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int TWELVE_VOLT_BIT  = 0;
  localparam int RESERVED_BIT     = 1;
  localparam int FAN_FIRST_BIT    = 2;
  localparam int DIODE_ONE_BIT    = 6;
  localparam int DIODE_TWO_BIT    = 7;
  localparam int START_BIT        = 0;
  localparam int FAN_COUNT        = 4;
  localparam int DIODE_COUNT      = 2;
  localparam int VID_WIDTH        = 5;

  // ------------------------------------------------------------------
  // Reset values and constants
  // ------------------------------------------------------------------
  localparam logic [7:0]  EVENT_STATUS_SECOND_RST = 8'h00;
  localparam logic [7:0]  FLAG_ENABLE_RST         = 8'hFD;
  localparam logic [7:0]  STATUS_VALID_MASK       = 8'hFD;
  localparam logic [7:0]  DIODE_FAULT_READING     = 8'h80;
  localparam logic [1:0]  RESP_OKAY               = 2'b00;
  localparam logic [1:0]  RESP_DECERR             = 2'b11;

endpackage

`default_nettype wire

/* verilog/fan_status_block.sv */
// Operation
// - Writes to the second event status register change none of its flags.
// - Reading the status register clears it only where conditions are inactive.
// - Bit 0 sets when 12V reading is at/below low or above high limit.
// - Bits 2-5 set when a fan count exceeds its 16-bit minimum.
// - Bit 6 flags diode one short/open, bit 7 diode two.
// - With start set and a diode fault, reading forced to 80h, limit flag set.
// - Diode fault flags survive reads while the fault persists.
// - Flags stay set until a read or enable clear, even if condition gone.
// - After a read, flags whose condition no longer holds are cleared.
// - Clearing a diode enable clears its fault flag and limit flag.
// - A disabled flag never goes from 0 to 1.
// - Disabled flag at 1 clears at the next reading update, not at once.
// - Readings update only with start set; pending disable waits for that.
// - VID pins show on bits 4-0 read-only; upper bits reserved.
// - Summary bit is 1 while any second status flag is set.
// - With start clear no status flag is set.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module fan_status_block
  import fan_status_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_WIDTH-1:0]      s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]      s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Measurement side
  input  wire logic                       twelve_volt_update_i,
  input  wire logic [7:0]                 twelve_volt_reading_i,
  input  wire logic [7:0]                 twelve_volt_low_limit_i,
  input  wire logic [7:0]                 twelve_volt_high_limit_i,
  input  wire logic [fan_status_pkg::FAN_COUNT-1:0]    fan_update_i,
  input  wire logic [16*fan_status_pkg::FAN_COUNT-1:0] fan_count_i,
  input  wire logic [16*fan_status_pkg::FAN_COUNT-1:0] fan_minimum_i,
  input  wire logic [fan_status_pkg::DIODE_COUNT-1:0]  diode_update_i,
  input  wire logic [fan_status_pkg::DIODE_COUNT-1:0]  diode_short_open_i,
  input  wire logic [8*fan_status_pkg::DIODE_COUNT-1:0] diode_temp_raw_i,
  input  wire logic                       status_first_read_i,
  input  wire logic [fan_status_pkg::VID_WIDTH-1:0] cpu_voltage_code_pins_i,
  // Results
  output logic [8*fan_status_pkg::DIODE_COUNT-1:0] diode_temp_o,
  output logic                            remote_diode_one_limit_flag_o,
  output logic                            remote_diode_two_limit_flag_o,
  output logic                            second_status_summary_o,
  output logic                            monitor_start_o,
  output logic                            irq_o
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [DIODE_COUNT-1:0] fault_meta;
  logic [DIODE_COUNT-1:0] fault_sync;
  logic [VID_WIDTH-1:0]   vid_meta;
  logic [VID_WIDTH-1:0]   vid_sync;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_meta <= '0;
      fault_sync <= '0;
      vid_meta   <= '0;
      vid_sync   <= '0;
    end else begin
      fault_meta <= diode_short_open_i;
      fault_sync <= fault_meta;
      vid_meta   <= cpu_voltage_code_pins_i;
      vid_sync   <= vid_meta;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic       start;
  logic [7:0] flag_enable;
  logic [7:0] flags;
  logic [7:0] cond_held;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [1:0] diode_limit;

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  logic [7:0] cond_now;
  logic [7:0] update;

  always_comb begin
    cond_now = '0;
    cond_now[TWELVE_VOLT_BIT] =
      (twelve_volt_reading_i <= twelve_volt_low_limit_i) ||
      (twelve_volt_reading_i > twelve_volt_high_limit_i);
    cond_now[DIODE_ONE_BIT] = fault_sync[0];
    cond_now[DIODE_TWO_BIT] = fault_sync[1];
    for (int k = 0; k < FAN_COUNT; k++) begin
      cond_now[FAN_FIRST_BIT+k] =
        fan_count_i[16*k +: 16] > fan_minimum_i[16*k +: 16];
    end
  end

  always_comb begin
    update = '0;
    update[TWELVE_VOLT_BIT] = twelve_volt_update_i;
    update[FAN_FIRST_BIT +: FAN_COUNT] = fan_update_i;
    update[DIODE_ONE_BIT +: DIODE_COUNT] = diode_update_i;
    update = update & {8{start}};
  end

  // Last measured condition, diode faults tracked live
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_held <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (update[i]) begin
          cond_held[i] <= cond_now[i];
        end
      end
    end
  end

  logic [7:0] active;
  always_comb begin
    active = cond_held;
    active[DIODE_ONE_BIT] = fault_sync[0];
    active[DIODE_TWO_BIT] = fault_sync[1];
  end

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  logic                  aw_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  w_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic                  do_read;
  logic                  status_read;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign status_read   = do_read &&
    (s_axi_araddr[11:0] == EVENT_STATUS_SECOND_ADDR);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      MONITOR_CTRL_ADDR, FLAG_ENABLE_ADDR, IRQ_STATUS_ADDR,
      IRQ_MASK_ADDR, DIODE_LIMIT_ADDR, EVENT_STATUS_SECOND_ADDR,
      CPU_VOLTAGE_CODE_ADDR: mapped = 1'b1;
      default:               mapped = 1'b0;
    endcase
  endfunction

  logic wr_low;
  assign wr_low = do_write && w_strb[0];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr[11:0]) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Software-written control
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start <= 1'b0;
    end else if (wr_low && aw_addr[11:0] == MONITOR_CTRL_ADDR) begin
      start <= w_data[START_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_enable <= FLAG_ENABLE_RST;
    end else if (wr_low && aw_addr[11:0] == FLAG_ENABLE_ADDR) begin
      flag_enable <= w_data[7:0] & STATUS_VALID_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= '0;
    end else if (wr_low && aw_addr[11:0] == IRQ_MASK_ADDR) begin
      irq_mask <= w_data[7:0] & STATUS_VALID_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Second event status flags (no write path at all)
  // ------------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] next_flags;

  always_comb begin
    flag_set = update & flag_enable & cond_now;
    flag_clr = update & ~flag_enable;
    if (status_read) begin
      flag_clr = flag_clr | ~active;
    end
    next_flags = ((flags & ~flag_clr) | flag_set)
                 & STATUS_VALID_MASK;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= EVENT_STATUS_SECOND_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // Summary follows the flag register from its own flip-flop
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_status_summary_o <= 1'b0;
    end else begin
      second_status_summary_o <= |next_flags;
    end
  end

  // ------------------------------------------------------------------
  // Diode readings and limit flags
  // ------------------------------------------------------------------
  generate
    for (genvar d = 0; d < DIODE_COUNT; d++) begin : g_diode
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          diode_temp_o[8*d +: 8] <= '0;
        end else if (start && fault_sync[d]) begin
          diode_temp_o[8*d +: 8] <= DIODE_FAULT_READING;
        end else begin
          diode_temp_o[8*d +: 8] <= diode_temp_raw_i[8*d +: 8];
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          diode_limit[d] <= 1'b0;
        end else if (flag_set[DIODE_ONE_BIT+d]) begin
          diode_limit[d] <= 1'b1;
        end else if (flag_clr[DIODE_ONE_BIT+d] && update[DIODE_ONE_BIT+d]) begin
          diode_limit[d] <= 1'b0;
        end else if (status_first_read_i && !fault_sync[d]) begin
          diode_limit[d] <= 1'b0;
        end
      end
    end
  endgenerate

  assign remote_diode_one_limit_flag_o = diode_limit[0];
  assign remote_diode_two_limit_flag_o = diode_limit[1];
  assign monitor_start_o               = start;

  // ------------------------------------------------------------------
  // Interrupt status: flag rise events, write one to clear
  // ------------------------------------------------------------------
  logic [7:0] irq_event;
  logic [7:0] irq_w1c;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;

  assign irq_event = next_flags & ~flags;
  assign irq_w1c   = (wr_low && aw_addr[11:0] == IRQ_STATUS_ADDR) ?
                     w_data[7:0] : 8'h00;
  assign next_irq_status = (irq_status & ~irq_w1c) | irq_event;
  assign next_irq_mask   = (wr_low && aw_addr[11:0] == IRQ_MASK_ADDR) ?
                           (w_data[7:0] & STATUS_VALID_MASK) : irq_mask;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt level from a flip-flop, no lag behind status or mask
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_irq_status & next_irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr[11:0])
      MONITOR_CTRL_ADDR:        rd_word[START_BIT] = start;
      FLAG_ENABLE_ADDR:         rd_word[7:0] = flag_enable;
      IRQ_STATUS_ADDR:          rd_word[7:0] = irq_status;
      IRQ_MASK_ADDR:            rd_word[7:0] = irq_mask;
      DIODE_LIMIT_ADDR:         rd_word[1:0] = diode_limit;
      EVENT_STATUS_SECOND_ADDR: rd_word[7:0] = flags;
      CPU_VOLTAGE_CODE_ADDR:    rd_word[VID_WIDTH-1:0] = vid_sync;
      default:                  rd_word = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(s_axi_araddr[11:0]) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // fan_status_block

`default_nettype wire

/* sim/sensor_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_front_model (
  input  wire logic       core_clk_i,
  input  wire logic [1:0] fault_req_i,
  input  wire logic [4:0] vid_req_i,
  output var  logic [1:0] diode_short_open_o,
  output var  logic [4:0] cpu_voltage_code_pins_o
);
  // Diode faults and VID levels follow the request one cycle late
  initial begin
    diode_short_open_o = 2'h0;
    cpu_voltage_code_pins_o = 5'h00;
  end
  always @(posedge core_clk_i) begin
    diode_short_open_o <= fault_req_i;
    cpu_voltage_code_pins_o <= vid_req_i;
  end
endmodule // sensor_front_model
`default_nettype wire

/* sim/fan_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_status_props
  import fan_status_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [fan_status_pkg::DIODE_COUNT-1:0] diode_update_i,
  input wire logic [fan_status_pkg::DIODE_COUNT-1:0] diode_short_open_i,
  input wire logic [8*fan_status_pkg::DIODE_COUNT-1:0] diode_temp_raw_i,
  input wire logic [8*fan_status_pkg::DIODE_COUNT-1:0] diode_temp_o,
  input wire logic        status_first_read_i,
  input wire logic        remote_diode_one_limit_flag_o,
  input wire logic        second_status_summary_o,
  input wire logic        monitor_start_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence ar_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence fault_seen_s;
    (monitor_start_o && diode_short_open_i[0]) [*4];
  endsequence
  read_answer_a: assert property (ar_taken_s |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  fault_force_a: assert property (
    fault_seen_s |=> diode_temp_o[7:0] == DIODE_FAULT_READING)
    else $error("fault reading not forced");
  raw_pass_a: assert property (
    !monitor_start_o |=> diode_temp_o == $past(diode_temp_raw_i))
    else $error("raw reading altered");
  flag_start_a: assert property (
    $rose(second_status_summary_o) |-> $past(monitor_start_o))
    else $error("flag set while stopped");
  limit_rise_a: assert property (
    $rose(remote_diode_one_limit_flag_o) |->
    $past(monitor_start_o && diode_update_i[0]))
    else $error("limit flag set without update");
  limit_fall_a: assert property (
    $fell(remote_diode_one_limit_flag_o) |->
    $past(status_first_read_i || diode_update_i[0]))
    else $error("limit flag cleared without cause");
endmodule // fan_status_props
bind fan_status_block fan_status_props fan_status_props_inst (
  .core_clk_i, .rst_n_i, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .diode_update_i, .diode_short_open_i, .diode_temp_raw_i, .diode_temp_o,
  .status_first_read_i, .remote_diode_one_limit_flag_o,
  .second_status_summary_o, .monitor_start_o);
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fan_status_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        v_upd = 0, frd = 0;
  logic [7:0]  v_rd = 8'h80, v_lo = 8'h40, v_hi = 8'hC0;
  logic [3:0]  f_upd = 0;
  logic [63:0] f_cnt = 0, f_min = 0;
  logic [1:0]  d_upd = 0, d_req = 0, d_flt;
  logic [15:0] d_raw = 0, d_tmp;
  logic [4:0]  vid_req = 0, vid;
  logic        lim1, lim2, summ, start, irq;
  int          num_errors = 0, checked = 0, cycles = 0, seed = 2;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  always #2 clk = ~clk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bq.push_back(RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic st(input logic [7:0] e);
    rd(EVENT_STATUS_SECOND_ADDR, {RESP_OKAY, 24'h0, e});
  endtask
  task automatic upd(input logic [7:0] m);
    {frd, d_upd, f_upd, v_upd} <= m;
    tick(1);
    {frd, d_upd, f_upd, v_upd} <= 8'h00;
    tick(1);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) check(bresp, bq.pop_front());
  end

  sensor_front_model sensor_front_model_inst (.core_clk_i(clk),
    .fault_req_i(d_req), .vid_req_i(vid_req), .diode_short_open_o(d_flt),
    .cpu_voltage_code_pins_o(vid));
  fan_status_block fan_status_block_inst (.core_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .twelve_volt_update_i(v_upd), .twelve_volt_reading_i(v_rd),
    .twelve_volt_low_limit_i(v_lo), .twelve_volt_high_limit_i(v_hi),
    .fan_update_i(f_upd), .fan_count_i(f_cnt), .fan_minimum_i(f_min),
    .diode_update_i(d_upd), .diode_short_open_i(d_flt),
    .diode_temp_raw_i(d_raw), .status_first_read_i(frd),
    .cpu_voltage_code_pins_i(vid), .diode_temp_o(d_tmp),
    .remote_diode_one_limit_flag_o(lim1),
    .remote_diode_two_limit_flag_o(lim2), .second_status_summary_o(summ),
    .monitor_start_o(start), .irq_o(irq));

  initial begin
    tick(16);
    rst_n <= 1;
    vid_req <= $random(seed);
    d_raw <= $random(seed);
    tick(6);
    st(8'h00);
    rd(FLAG_ENABLE_ADDR, {RESP_OKAY, 32'hFD});
    rd(12'h200, {RESP_DECERR, 32'h0});
    wr(CPU_VOLTAGE_CODE_ADDR, 32'hFF);
    rd(CPU_VOLTAGE_CODE_ADDR, {RESP_OKAY, 27'h0, vid_req});
    check(d_tmp, d_raw);
    $display("reset and map test done");
    wr(MONITOR_CTRL_ADDR, 32'h1);
    check(start, 1'b1);
    wr(IRQ_MASK_ADDR, 32'h1);
    v_rd <= v_lo;
    upd(8'h01);
    v_rd <= v_hi;
    upd(8'h01);
    check({summ, irq}, 2'b11);
    wr(IRQ_STATUS_ADDR, 32'h1);
    check(irq, 1'b0);
    wr(IRQ_MASK_ADDR, 32'h0);
    wr(EVENT_STATUS_SECOND_ADDR, 32'h0);
    st(8'h01);
    st(8'h00);
    upd(8'h01);
    st(8'h00);
    v_rd <= v_hi + 8'h01;
    upd(8'h01);
    st(8'h01);
    st(8'h01);
    check(irq, 1'b0);
    rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h1});
    v_rd <= v_hi;
    upd(8'h01);
    st(8'h01);
    st(8'h00);
    $display("twelve volt test done");
    for (int k = 0; k < 4; k++) begin
      f_min[16*k +: 16] <= $random(seed) & 16'h7FFF;
      tick(1);
      f_cnt[16*k +: 16] <= f_min[16*k +: 16];
      upd(8'h02 << k);
      st((8'h04 << k) - 8'h04);
      f_cnt[16*k +: 16] <= f_min[16*k +: 16] + 16'h1;
      upd(8'h02 << k);
      st((8'h08 << k) - 8'h04);
    end
    f_cnt <= f_min;
    upd(8'h1E);
    st(8'h3C);
    st(8'h00);
    f_cnt <= f_min + 64'h1;
    upd(8'h02);
    wr(MONITOR_CTRL_ADDR, 32'h0);
    wr(FLAG_ENABLE_ADDR, 32'hF9);
    upd(8'h02);
    check(summ, 1'b1);
    wr(MONITOR_CTRL_ADDR, 32'h1);
    check(summ, 1'b1);
    upd(8'h02);
    check(summ, 1'b0);
    st(8'h00);
    wr(FLAG_ENABLE_ADDR, 32'hFD);
    f_cnt <= f_min;
    wr(MONITOR_CTRL_ADDR, 32'h0);
    v_rd <= v_lo;
    upd(8'h1F);
    st(8'h00);
    v_rd <= v_hi;
    wr(MONITOR_CTRL_ADDR, 32'h1);
    $display("fan and enable test done");
    d_req <= 2'b01;
    tick(6);
    check(d_tmp[7:0], DIODE_FAULT_READING);
    upd(8'h20);
    check(lim1, 1'b1);
    rd(DIODE_LIMIT_ADDR, {RESP_OKAY, 32'h1});
    st(8'h40);
    st(8'h40);
    d_req <= 2'b00;
    tick(6);
    st(8'h40);
    st(8'h00);
    upd(8'h80);
    check(lim1, 1'b0);
    d_req <= 2'b10;
    tick(6);
    upd(8'h40);
    check({lim2, summ}, 2'b11);
    wr(FLAG_ENABLE_ADDR, 32'h7D);
    upd(8'h40);
    check({lim2, summ}, 2'b00);
    st(8'h00);
    $display("diode test done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
